// file: inc/lcdhi_params.svh
`ifndef LCDHI_PARAMS_SVH
`define LCDHI_PARAMS_SVH

// Data bus
`define LCDHI_DATA_W 8
`define LCDHI_BUSY_BIT 7

// Driver counts
`define LCDHI_NUM_COMMON 16
`define LCDHI_NUM_SEGMENT 61

// Bus style strap value held until the reset pin level has first been sampled (1 = enable-strobe)
`define LCDHI_STYLE_RST 1'b1

// Master/slave value held until the select pin has been sampled (1 = master)
`define LCDHI_MASTER_RST 1'b1

// Synchroniser width: reset, enable/read, rw/write, select, master, frame, clock, data
`define LCDHI_SYNC_W 15

`endif

// file: inc/lcdhi_pkg.sv
package lcdhi_pkg;

  // Bus style picked by the reset pin edge
  typedef enum logic
  {
    LCDHI_STYLE_STROBE,
    LCDHI_STYLE_ENABLE
  } lcdhi_style_t;

  // Drive levels, highest supply first
  typedef enum logic [2:0]
  {
    LCDHI_LVL_VDD,
    LCDHI_LVL_V1,
    LCDHI_LVL_V2,
    LCDHI_LVL_V3,
    LCDHI_LVL_V4,
    LCDHI_LVL_V5
  } lcdhi_level_t;

  // Read side of the processor port
  typedef enum logic
  {
    LCDHI_BUS_IDLE,
    LCDHI_BUS_READ
  } lcdhi_bus_state_t;

endpackage : lcdhi_pkg

// file: hdl/lcdhi_sync.sv
`timescale 1ns/1ps

module lcdhi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // Inputs from outside the clock domain
  output logic [WIDTH-1:0] sync_out // Synchronised copy
);

  logic [WIDTH-1:0] stage1;

  // =====================================================
  // Two-stage synchroniser
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : lcdhi_sync

// file: hdl/lcdhi_top.sv
`timescale 1ns/1ps
`include "lcdhi_params.svh"

// Operation
// - Enable-strobe style: enable strobe is active high
// - Separate-strobe style: read strobe is active low
// - Drive data bus only while read active
// - Enable-strobe style: read/write high means read
// - Separate-strobe style: write strobe is active low
// - Capture data at write strobe rising edge
// - Select high is display data, low instruction
// - Eight-bit tri-state bidirectional data bus
// - Either edge on reset pin resets device
// - Level after reset edge picks bus style
// - Master/slave select pin sets operating role
// - Frame alternation output in master, input slave
// - Common level from frame and counter bit
// - Segment level from frame and memory bit
// - Slave scans commons in reversed order
// - Busy shown on bit 7 of status

module lcdhi_top #(
  parameter int DATA_W = `LCDHI_DATA_W,
  parameter int NUM_COMMON = `LCDHI_NUM_COMMON,
  parameter int NUM_SEGMENT = `LCDHI_NUM_SEGMENT
) (
  input wire logic clk, // System clock, 10 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic reset_pin, // Reset and bus style pin
  input wire logic enable_read_pin, // Enable strobe or read strobe (low)
  input wire logic rw_write_pin, // Read/write select or write strobe (low)
  input wire logic data_instruction_select, // High display data, low instruction
  input wire logic [DATA_W-1:0] data_in, // Data bus input
  output logic [DATA_W-1:0] data_out, // Data bus output
  output logic data_oe, // Data bus output enable, high drives
  input wire logic master_select_pin, // High master, low slave
  input wire logic frame_alternation_in, // Frame alternation from master
  output logic frame_alternation_out, // Frame alternation to slaves
  output logic frame_alternation_oe, // Frame alternation output enable
  input wire logic external_clock_pin, // External clock on second oscillator pin
  output logic clock_tick, // One pulse per external clock rise
  input wire logic frame_generate, // Frame signal from timing generator
  input wire logic busy, // Internal operation in progress
  input wire logic [DATA_W-1:0] read_data, // Display data for reads
  input wire logic [DATA_W-1:0] status_data, // Status bits for status reads
  output logic read_request, // Pulse at start of read
  output logic read_is_data, // Read is display data
  output logic write_valid, // Pulse with captured write
  output logic write_is_data, // Write is display data
  output logic [DATA_W-1:0] write_data, // Captured write byte
  output logic write_dropped, // Pulse when write refused while busy
  output logic device_reset, // Pulse on reset pin edge
  output lcdhi_pkg::lcdhi_style_t bus_style, // Active bus style
  output logic master_mode, // High in master mode
  input wire logic [NUM_COMMON-1:0] common_select, // Common counter select bits
  input wire logic [NUM_SEGMENT-1:0] segment_data, // Latched display bits
  output logic [3*NUM_COMMON-1:0] common_drive_output, // Common level codes
  output logic [3*NUM_SEGMENT-1:0] segment_drive_output // Segment level codes
);

  import lcdhi_pkg::*;

  // =====================================================
  // Pin synchronisation
  logic [`LCDHI_SYNC_W-1:0] pins_sync;
  logic rst_s;
  logic en_s;
  logic rw_s;
  logic sel_s;
  logic ms_s;
  logic fr_s;
  logic xclk_s;
  logic [DATA_W-1:0] data_s;

  lcdhi_sync #(
    .WIDTH(`LCDHI_SYNC_W)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({reset_pin, enable_read_pin, rw_write_pin, data_instruction_select,
      master_select_pin, frame_alternation_in, external_clock_pin, data_in}),
    .sync_out(pins_sync)
  );

  assign {rst_s, en_s, rw_s, sel_s, ms_s, fr_s, xclk_s, data_s} = pins_sync;

  // =====================================================
  // Strobe decoding
  function automatic logic read_active_f(input lcdhi_style_t style, input logic en,
    input logic rw);
    if (style == LCDHI_STYLE_ENABLE)
    begin
      read_active_f = en && rw;
    end
    else
    begin
      read_active_f = !en;
    end
  endfunction : read_active_f

  function automatic logic write_phase_f(input lcdhi_style_t style, input logic en,
    input logic rw);
    if (style == LCDHI_STYLE_ENABLE)
    begin
      write_phase_f = en && !rw;
    end
    else
    begin
      write_phase_f = !rw;
    end
  endfunction : write_phase_f

  // =====================================================
  // Reset pin edge and bus style strap
  logic rst_prev;
  logic [2:0] settle;
  logic rst_edge;

  // Synchroniser is cleared by reset; wait until it holds real pin levels
  assign rst_edge = settle[2] && (rst_s != rst_prev);

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rst_prev <= 1'b0;
      settle <= 3'h0;
      bus_style <= lcdhi_style_t'(`LCDHI_STYLE_RST);
      device_reset <= 1'b0;
    end
    else
    begin
      rst_prev <= rst_s;
      settle <= {settle[1:0], 1'b1};
      device_reset <= rst_edge;
      if ((settle[1] && !settle[2]) || rst_edge)
      begin
        bus_style <= rst_s ? LCDHI_STYLE_ENABLE : LCDHI_STYLE_STROBE;
      end
    end
  end

  // =====================================================
  // Master/slave and frame alternation
  logic fr_eff;

  assign fr_eff = master_mode ? frame_alternation_out : fr_s;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      master_mode <= `LCDHI_MASTER_RST;
    end
    else if (settle[1])
    begin
      master_mode <= ms_s;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      frame_alternation_out <= 1'b0;
      frame_alternation_oe <= 1'b0;
    end
    else
    begin
      frame_alternation_out <= frame_generate;
      frame_alternation_oe <= settle[1] && ms_s;
    end
  end

  // =====================================================
  // External clock
  logic xclk_prev;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      xclk_prev <= 1'b0;
      clock_tick <= 1'b0;
    end
    else
    begin
      xclk_prev <= xclk_s;
      clock_tick <= xclk_s && !xclk_prev;
    end
  end

  // =====================================================
  // Read side
  lcdhi_bus_state_t bus_state;
  logic rd_act;

  assign rd_act = read_active_f(bus_style, en_s, rw_s);

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      bus_state <= LCDHI_BUS_IDLE;
      read_request <= 1'b0;
      read_is_data <= 1'b0;
      data_oe <= 1'b0;
    end
    else
    begin
      read_request <= 1'b0;
      case (bus_state)
        LCDHI_BUS_IDLE:
        begin
          if (rd_act && settle[2] && !rst_edge)
          begin
            bus_state <= LCDHI_BUS_READ;
            read_request <= 1'b1;
            read_is_data <= sel_s;
            data_oe <= 1'b1;
          end
        end
        LCDHI_BUS_READ:
        begin
          if (!rd_act || rst_edge)
          begin
            bus_state <= LCDHI_BUS_IDLE;
            data_oe <= 1'b0;
          end
        end
        default:
        begin
          bus_state <= LCDHI_BUS_IDLE;
          data_oe <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      data_out <= '0;
    end
    else if (read_is_data)
    begin
      data_out <= read_data;
    end
    else
    begin
      data_out <= status_data;
      data_out[`LCDHI_BUSY_BIT] <= busy;
    end
  end

  // =====================================================
  // Write side
  logic wr_prev;
  logic wr_phase;
  logic wr_end;

  assign wr_phase = write_phase_f(bus_style, en_s, rw_s);
  assign wr_end = wr_prev && !wr_phase && settle[2] && !rst_edge;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wr_prev <= 1'b0;
      write_valid <= 1'b0;
      write_dropped <= 1'b0;
      write_is_data <= 1'b0;
      write_data <= '0;
    end
    else
    begin
      wr_prev <= wr_phase;
      write_valid <= wr_end && !busy;
      write_dropped <= wr_end && busy;
      if (wr_end && !busy)
      begin
        write_data <= data_s;
        write_is_data <= sel_s;
      end
    end
  end

  // =====================================================
  // Drive level selection
  function automatic lcdhi_level_t common_level_f(input logic fr, input logic sel);
    if (fr)
    begin
      common_level_f = sel ? LCDHI_LVL_V5 : LCDHI_LVL_V1;
    end
    else
    begin
      common_level_f = sel ? LCDHI_LVL_VDD : LCDHI_LVL_V4;
    end
  endfunction : common_level_f

  function automatic lcdhi_level_t segment_level_f(input logic fr, input logic bit_on);
    if (fr)
    begin
      segment_level_f = bit_on ? LCDHI_LVL_VDD : LCDHI_LVL_V2;
    end
    else
    begin
      segment_level_f = bit_on ? LCDHI_LVL_V5 : LCDHI_LVL_V3;
    end
  endfunction : segment_level_f

  genvar gi;

  generate
    for (gi = 0; gi < NUM_COMMON; gi++)
    begin : g_common
      logic sel_bit;

      // Slave takes its select bits mirrored
      assign sel_bit = master_mode ? common_select[gi] : common_select[NUM_COMMON-1-gi];

      always_ff @(posedge clk)
      begin
        if (!reset_n)
        begin
          common_drive_output[3*gi +: 3] <= LCDHI_LVL_VDD;
        end
        else
        begin
          common_drive_output[3*gi +: 3] <= common_level_f(fr_eff, sel_bit);
        end
      end
    end

    for (gi = 0; gi < NUM_SEGMENT; gi++)
    begin : g_segment
      always_ff @(posedge clk)
      begin
        if (!reset_n)
        begin
          segment_drive_output[3*gi +: 3] <= LCDHI_LVL_VDD;
        end
        else
        begin
          segment_drive_output[3*gi +: 3] <= segment_level_f(fr_eff, segment_data[gi]);
        end
      end
    end
  endgenerate

endmodule : lcdhi_top

// file: test/lcdhi_asserts.sv
`timescale 1ns/1ps
module lcdhi_asserts #(
  parameter int DATA_W = 8,
  parameter int NUM_COMMON = 16,
  parameter int NUM_SEGMENT = 61
) (
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic busy, // Busy
  input wire logic frame_generate, // Frame
  input wire logic [DATA_W-1:0] read_data, // Read byte
  input wire logic [NUM_COMMON-1:0] common_select, // Select bits
  input wire logic [NUM_SEGMENT-1:0] segment_data, // Memory bits
  input wire logic [DATA_W-1:0] data_out, // Bus out
  input wire logic data_oe, // Bus enable
  input wire logic frame_alternation_out, // Frame out
  input wire logic read_request, // Read start
  input wire logic read_is_data, // Read kind
  input wire logic write_valid, // Write pulse
  input wire logic write_dropped, // Drop pulse
  input wire logic device_reset, // Reset pulse
  input wire lcdhi_pkg::lcdhi_style_t bus_style, // Style
  input wire logic master_mode, // Master
  input wire logic [3*NUM_COMMON-1:0] common_drive_output, // Common codes
  input wire logic [3*NUM_SEGMENT-1:0] segment_drive_output // Segment codes
);
  import lcdhi_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========
  // Properties
  style_edge_a: assert property ($past(reset_n, 4) && $changed(bus_style) |-> device_reset)
    else $error("style change without reset pulse");
  com_level_a: assert property ($past(reset_n) && master_mode && $past(master_mode)
    && $stable(frame_alternation_out)
    && $stable(common_select[0]) |-> common_drive_output[2:0] == (frame_alternation_out ?
    (common_select[0] ? 3'h5 : 3'h1) : (common_select[0] ? 3'h0 : 3'h4)))
    else $error("common level wrong");
  seg_level_a: assert property ($past(reset_n) && master_mode && $past(master_mode)
    && $stable(frame_alternation_out)
    && $stable(segment_data[0]) |-> segment_drive_output[2:0] == (frame_alternation_out ?
    (segment_data[0] ? 3'h0 : 3'h2) : (segment_data[0] ? 3'h5 : 3'h3)))
    else $error("segment level wrong");
  fr_follow_a: assert property ($past(reset_n) |-> frame_alternation_out == $past(frame_generate))
    else $error("frame output not following");
  oe_start_a: assert property ($rose(data_oe) |-> read_request)
    else $error("bus driven without read");
  busy_bit_a: assert property (data_oe && $past(data_oe) && !read_is_data |-> data_out[7] == $past(busy))
    else $error("busy bit wrong");
  rd_data_a: assert property (data_oe && $past(data_oe) && read_is_data |-> data_out == $past(read_data))
    else $error("read byte wrong");
  wr_pulse_a: assert property (write_valid |-> !write_dropped ##1 !write_valid)
    else $error("write pulse wrong");
endmodule : lcdhi_asserts

bind lcdhi_top lcdhi_asserts #(.DATA_W(DATA_W), .NUM_COMMON(NUM_COMMON),
  .NUM_SEGMENT(NUM_SEGMENT)) i_chk (.clk(clk), .reset_n(reset_n), .busy(busy),
  .frame_generate(frame_generate), .read_data(read_data), .common_select(common_select),
  .segment_data(segment_data), .data_out(data_out), .data_oe(data_oe),
  .frame_alternation_out(frame_alternation_out), .read_request(read_request),
  .read_is_data(read_is_data), .write_valid(write_valid), .write_dropped(write_dropped),
  .device_reset(device_reset), .bus_style(bus_style), .master_mode(master_mode),
  .common_drive_output(common_drive_output), .segment_drive_output(segment_drive_output));

// file: test/lcdhi_mpu.sv
`timescale 1ns/1ps
module lcdhi_mpu (
  input wire logic clk, // Clock
  output logic en_rd, // Enable or read strobe
  output logic rw_wr, // Direction or write strobe
  output logic sel, // Data or instruction
  output logic [7:0] data // Bus byte
);
  initial
  begin
    en_rd = 1'b0;
    rw_wr = 1'b1;
    sel = 1'b0;
    data = 8'h00;
  end
  task automatic park(input logic e);
    en_rd = e;
  endtask : park
  // Strobe held 8 clocks, data held 5 clocks past the end edge
  task automatic xfer(input logic enb, input logic rd, input logic s, input logic [7:0] d);
    @(negedge clk);
    sel = s;
    data = d;
    if (enb)
    begin
      rw_wr = rd;
      en_rd = 1'b1;
    end
    else if (rd)
      en_rd = 1'b0;
    else
      rw_wr = 1'b0;
    repeat (8) @(negedge clk);
    en_rd = !enb;
    if (!enb)
      rw_wr = 1'b1;
    repeat (5) @(negedge clk);
    data = ~d;
    rw_wr = 1'b1;
  endtask : xfer
endmodule : lcdhi_mpu

// file: test/lcdhi_tb_top.sv
`timescale 1ns/1ps
module lcdhi_tb_top;
  import lcdhi_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic reset_pin = 1'b1;
  logic busy = 1'b0;
  logic frame_generate = 1'b0;
  logic frame_alternation_in = 1'b0;
  logic external_clock_pin = 1'b0;
  logic master_select_pin = 1'b1;
  logic [15:0] common_select = 16'h0000;
  logic [60:0] segment_data = 61'h0;
  logic [7:0] read_data = 8'h00;
  logic [7:0] status_data = 8'h00;
  logic enable_read_pin, rw_write_pin, data_instruction_select, data_oe, clock_tick;
  logic frame_alternation_out, frame_alternation_oe, read_request, read_is_data;
  logic write_valid, write_is_data, write_dropped, device_reset, master_mode;
  logic [7:0] data_in, data_out, write_data;
  lcdhi_style_t bus_style;
  logic [47:0] common_drive_output;
  logic [182:0] segment_drive_output;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc_n = 0;
  int rst_cnt = 0;
  int tick_cnt = 0;
  logic mon_on = 1'b0;
  logic oe_d = 1'b0;
  logic oe_dd = 1'b0;
  logic [10:0] seen, expv;
  logic [10:0] exp_q[$];
  lcdhi_level_t ctab[4] = '{LCDHI_LVL_V4, LCDHI_LVL_VDD, LCDHI_LVL_V1, LCDHI_LVL_V5};
  lcdhi_level_t stab[4] = '{LCDHI_LVL_V3, LCDHI_LVL_V5, LCDHI_LVL_V2, LCDHI_LVL_VDD};

  always #50 clk = ~clk;

  lcdhi_top i_dut (.clk(clk), .reset_n(reset_n), .reset_pin(reset_pin),
    .enable_read_pin(enable_read_pin), .rw_write_pin(rw_write_pin),
    .data_instruction_select(data_instruction_select), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .master_select_pin(master_select_pin),
    .frame_alternation_in(frame_alternation_in),
    .frame_alternation_out(frame_alternation_out),
    .frame_alternation_oe(frame_alternation_oe), .external_clock_pin(external_clock_pin),
    .clock_tick(clock_tick), .frame_generate(frame_generate), .busy(busy),
    .read_data(read_data), .status_data(status_data), .read_request(read_request),
    .read_is_data(read_is_data), .write_valid(write_valid), .write_is_data(write_is_data),
    .write_data(write_data), .write_dropped(write_dropped), .device_reset(device_reset),
    .bus_style(bus_style), .master_mode(master_mode), .common_select(common_select),
    .segment_data(segment_data), .common_drive_output(common_drive_output),
    .segment_drive_output(segment_drive_output));
  lcdhi_mpu i_mpu (.clk(clk), .en_rd(enable_read_pin), .rw_wr(rw_write_pin),
    .sel(data_instruction_select), .data(data_in));

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic results();
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // One transfer; the expected outcome is queued first
  task automatic op(input logic rd, input logic s, input logic bz);
    logic [7:0] b;
    b = 8'($urandom);
    read_data = 8'($urandom);
    status_data = 8'($urandom);
    busy = bz;
    if (rd)
      exp_q.push_back({2'd1, s, (s ? read_data : {bz, status_data[6:0]})});
    else
      exp_q.push_back(bz ? 11'h400 : {2'd0, s, b});
    i_mpu.xfer(reset_pin, rd, s, b);
    busy = 1'b0;
  endtask : op

  // ==========
  // Monitor
  always @(negedge clk)
  begin
    if (device_reset === 1'b1)
      rst_cnt++;
    if (clock_tick === 1'b1)
      tick_cnt++;
    if (mon_on && (write_valid | write_dropped | (data_oe & oe_d & ~oe_dd)) === 1'b1)
    begin
      seen = write_valid ? {2'd0, write_is_data, write_data} :
        write_dropped ? 11'h400 : {2'd1, read_is_data, data_out};
      expv = exp_q.size() ? exp_q.pop_front() : 11'h7FF;
      chk("transfer", seen, expv);
    end
    oe_dd = oe_d;
    oe_d = data_oe;
  end

  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 5000)
    begin
      mismatches++;
      results();
    end
  end

  initial
  begin
    void'($urandom(79180));
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    mon_on = 1'b1;
    for (int st = 0; st < 3; st++)
    begin
      if (st > 0)
      begin
        mon_on = 1'b0;
        reset_pin = ~reset_pin;
        i_mpu.park(~reset_pin);
        repeat (10) @(negedge clk);
        mon_on = 1'b1;
      end
      chk("style", bus_style, reset_pin);
      op(1'b0, 1'b1, 1'b0);
      op(1'b0, 1'b0, 1'b0);
      op(1'b0, 1'b1, 1'b1);
      op(1'b1, 1'b1, 1'b0);
      op(1'b1, 1'b0, 1'b1);
      op(1'b1, 1'b0, 1'b0);
    end
    for (int m = 1; m >= 0; m--)
      for (int i = 0; i < 4; i++)
      begin
        master_select_pin = m[0];
        frame_generate = i[1];
        frame_alternation_in = i[1];
        common_select = m[0] ? {{15{~i[0]}}, i[0]} : {i[0], {15{~i[0]}}};
        segment_data = {{60{~i[0]}}, i[0]};
        repeat (8) @(negedge clk);
        chk("common", common_drive_output[2:0], ctab[i]);
        chk("segment", segment_drive_output[2:0], stab[i]);
        chk("frame_oe", frame_alternation_oe, m[0]);
        chk("master", master_mode, m[0]);
        chk("frame_out", frame_alternation_out, i[1]);
      end
    repeat (5)
    begin
      external_clock_pin = 1'b1;
      repeat (4) @(negedge clk);
      external_clock_pin = 1'b0;
      repeat (4) @(negedge clk);
    end
    chk("ticks", 16'(tick_cnt), 16'h0005);
    chk("resets", 16'(rst_cnt), 16'h0002);
    chk("pending", 16'(exp_q.size()), 16'h0000);
    results();
  end
endmodule : lcdhi_tb_top
